// ==== hw/bitband_xlate.sv ====
`timescale 1ns/100ps
`include "addr_decode_regs.svh"

module bitband_xlate (
   input  wire logic [31:0]          i_addr,
   input  wire logic                 i_is_core,
   output      addr_decode_pkg::bb_t o_bb
);

   logic sram_hit;
   logic periph_hit;

   assign sram_hit   = (i_addr >= `SRAM_ALIAS_BASE) &&
                       (i_addr < (`SRAM_ALIAS_BASE + `ALIAS_SIZE));
   assign periph_hit = (i_addr >= `PERIPH_ALIAS_BASE) &&
                       (i_addr < (`PERIPH_ALIAS_BASE + `ALIAS_SIZE));

   always_comb begin
      o_bb.alias_hit = i_is_core && (sram_hit || periph_hit);
      o_bb.bitpos    = i_addr[4:2];
      if (i_is_core && sram_hit) begin
         o_bb.addr = `SRAM_BASE + {12'h000, i_addr[24:5]};
      end else if (i_is_core && periph_hit) begin
         o_bb.addr = `PERIPH_BASE + {12'h000, i_addr[24:5]};
      end else begin
         o_bb.addr = i_addr;
      end
   end

endmodule

// ==== hw/clk_enable_ctl.sv ====
`timescale 1ns/100ps
`include "addr_decode_regs.svh"

module clk_enable_ctl (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_b,
   input  wire addr_decode_pkg::clken_upd_t i_upd,
   output      addr_decode_pkg::clken_t     o_en
);

   addr_decode_pkg::clken_t en_r;
   addr_decode_pkg::clken_t en_nxt;

   always_comb begin
      en_nxt = en_r;
      if (i_upd.wr[0]) begin
         en_nxt.highspeed_bus_clock_enable = i_upd.val;
      end
      if (i_upd.wr[1]) begin
         en_nxt.periph_bus1_clock_enable = i_upd.val;
      end
      if (i_upd.wr[2]) begin
         en_nxt.periph_bus2_clock_enable = i_upd.val;
      end
   end

   // Only the SRAM and flash interface clocks run out of reset.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         en_r.highspeed_bus_clock_enable <= `HS_CLKEN_RST;
         en_r.periph_bus1_clock_enable   <= `BUS_CLKEN_RST;
         en_r.periph_bus2_clock_enable   <= `BUS_CLKEN_RST;
      end else begin
         en_r <= en_nxt;
      end
   end

   assign o_en = en_r;

endmodule

// ==== hw/system_address_decode_bitband.sv ====
`timescale 1ns/100ps
`include "addr_decode_regs.svh"

// Functional notes
// - Bus bridges fully synchronous, no handshake crossing.
// - Reset gates all clocks but SRAM, flash.
// - Narrow peripheral-bus writes become replicated word writes.
// - Little endian: low address holds low byte.
// - Top three address bits pick 512 MB region.
// - Unassigned addresses decode as reserved space.
// - High-speed bus windows from 0x40020000 to 0x40026000.
// - Bus2 range 0x40010000-0x40017FFF routed to its peripherals.
// - Bus1 range from 0x40000000, reserved from 0x40007800.
// - SRAM up to 96 KB, byte/half/word access.
// - SRAM and peripherals each have bit-band alias.
// - Alias write is atomic read-modify-write; single-bit except on Bus1/Bus2, which get the modified byte on all lanes.
// - Alias = base + byteoffset*32 + bit*4.
// - Alias read returns 0x01 or 0x00.
// - SRAM alias at 0x22000000 maps SRAM bits.
// - Only core accesses are alias-translated.
module system_address_decode_bitband (
   input  wire logic                                     i_clk,
   input  wire logic                                     i_rst_b,
   input  wire addr_decode_pkg::up_req_t                 i_req,
   output      logic                                     o_req_ready,
   output      addr_decode_pkg::up_rsp_t                 o_rsp,
   output      addr_decode_pkg::tgt_req_t [`TGT_NUM-1:0] o_tgt,
   input  wire addr_decode_pkg::tgt_rsp_t [`TGT_NUM-1:0] i_tgt,
   input  wire addr_decode_pkg::clken_upd_t              i_clken_upd,
   output      addr_decode_pkg::clken_t                  o_clk_en
);

   // ----------------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------------

   function automatic logic in_range(input logic [31:0] a, input logic [31:0] base,
                                     input logic [31:0] size);
      in_range = (a >= base) && (a < (base + size));
   endfunction

   // Byte lanes follow the little-endian layout: lane 0 holds address offset 0.
   function automatic logic [3:0] lane_strb(input logic [1:0] a, input logic [1:0] size);
      case (size)
         `SIZE_BYTE: lane_strb = 4'h1 << a;
         `SIZE_HALF: lane_strb = a[1] ? 4'hc : 4'h3;
         default:    lane_strb = 4'hf;
      endcase
   endfunction

   // Narrow data is taken from its own lane and copied onto every lane.
   function automatic logic [31:0] replicate(input logic [31:0] d, input logic [1:0] a,
                                             input logic [1:0] size);
      logic [31:0] sh;
      sh = 32'h0000_0000;
      case (size)
         `SIZE_BYTE: begin
            sh        = d >> {a, 3'h0};
            replicate = {4{sh[7:0]}};
         end
         `SIZE_HALF: begin
            sh        = d >> {a[1], 4'h0};
            replicate = {2{sh[15:0]}};
         end
         default: begin
            replicate = d;
         end
      endcase
   endfunction

   function automatic logic is_apb(input logic [2:0] t);
      is_apb = (t == `TGT_BUS1) || (t == `TGT_BUS2);
   endfunction

   // Map an address onto a target and a 1 KB window index.
   function automatic addr_decode_pkg::dec_t decode(input logic [31:0] a);
      addr_decode_pkg::dec_t d;
      logic [4:0]            idx;
      d   = '0;
      idx = a[`WIN_MSB:`WIN_LSB];
      case (a[`RGN_MSB:`RGN_LSB])
         `RGN_CODE: begin
            if (in_range(a, `FLASH_BASE, `FLASH_SIZE)) begin
               d.ok  = 1'b1;
               d.tgt = `TGT_FLASH;
               d.win = `HS_WIN_FLASH;
            end
         end
         `RGN_SRAM: begin
            if (in_range(a, `SRAM_BASE, `SRAM_SIZE)) begin
               d.ok  = 1'b1;
               d.tgt = `TGT_SRAM;
               d.win = `HS_WIN_SRAM;
            end
         end
         `RGN_PERIPH: begin
            if (in_range(a, `BUS1_BASE, `BUS1_SIZE)) begin
               d.ok  = 1'(`BUS1_WIN_MASK >> idx);
               d.tgt = `TGT_BUS1;
               d.win = idx;
            end else if (in_range(a, `BUS2_BASE, `BUS2_SIZE)) begin
               d.ok  = 1'(`BUS2_WIN_MASK >> idx);
               d.tgt = `TGT_BUS2;
               d.win = (idx >= `QSPI_WIN) ? `QSPI_WIN : idx;
            end else if (in_range(a, `SDIO_BASE, `SDIO_SIZE)) begin
               d.ok  = 1'b1;
               d.tgt = `TGT_HS;
               d.win = `SDIO_WIN;
            end else if (in_range(a, `HS_BASE, `HS_SIZE)) begin
               d.ok  = 1'(`HS_WIN_MASK >> idx);
               d.tgt = `TGT_HS;
               d.win = idx;
            end
         end
         default: begin
            d.ok = 1'b0;
         end
      endcase
      decode = d;
   endfunction

   function automatic logic clk_on(input addr_decode_pkg::dec_t d,
                                   input addr_decode_pkg::clken_t e);
      case (d.tgt)
         `TGT_BUS1: clk_on = e.periph_bus1_clock_enable[d.win];
         `TGT_BUS2: clk_on = e.periph_bus2_clock_enable[d.win];
         `TGT_HS:   clk_on = e.highspeed_bus_clock_enable[d.win];
         `TGT_SRAM: clk_on = e.highspeed_bus_clock_enable[`HS_WIN_SRAM];
         default:   clk_on = e.highspeed_bus_clock_enable[`HS_WIN_FLASH];
      endcase
   endfunction

   // ----------------------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------------------

   addr_decode_pkg::bb_t      bb;
   addr_decode_pkg::clken_t   clk_en;
   addr_decode_pkg::dec_t     dec;
   addr_decode_pkg::tgt_rsp_t sel_rsp;
   addr_decode_pkg::core_st_t s_r;
   addr_decode_pkg::core_st_t s_nxt;

   bitband_xlate i_bitband_xlate (
      .i_addr    (i_req.addr),
      .i_is_core (i_req.is_core),
      .o_bb      (bb)
   );

   clk_enable_ctl i_clk_enable_ctl (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_upd   (i_clken_upd),
      .o_en    (clk_en)
   );

   assign dec     = decode(bb.addr);
   assign sel_rsp = i_tgt[s_r.tgt];

   // ----------------------------------------------------------------------------
   // Transfer sequencer
   // ----------------------------------------------------------------------------

   always_comb begin
      logic [31:0] byte_sh;
      logic [7:0]  new_byte;
      logic        cur_bit;
      byte_sh  = sel_rsp.rdata >> {s_r.addr[1:0], 3'h0};
      cur_bit  = byte_sh[s_r.bitpos];
      new_byte = byte_sh[7:0];
      new_byte[s_r.bitpos] = s_r.bb_val;
      s_nxt = s_r;
      case (s_r.state)
         addr_decode_pkg::ST_IDLE: begin
            s_nxt.rdy      = 1'b1;
            s_nxt.rsp.done = 1'b0;
            if (i_req.valid && s_r.rdy) begin
               s_nxt.rdy    = 1'b0;
               s_nxt.tgt    = dec.tgt;
               s_nxt.win    = dec.win;
               s_nxt.addr   = bb.addr;
               s_nxt.bitpos = bb.bitpos;
               s_nxt.bb_wr  = i_req.write;
               s_nxt.bb_val = i_req.wdata[0];
               // A gated peripheral is refused, so software must enable it first.
               if (!dec.ok || !clk_on(dec, clk_en)) begin
                  s_nxt.state     = addr_decode_pkg::ST_RESP;
                  s_nxt.rsp.done  = 1'b1;
                  s_nxt.rsp.err   = 1'b1;
                  s_nxt.rsp.rdata = 32'h0000_0000;
               end else if (bb.alias_hit) begin
                  s_nxt.state = addr_decode_pkg::ST_RMW_RD;
                  s_nxt.tv    = 5'h01 << dec.tgt;
                  s_nxt.wr    = 1'b0;
                  s_nxt.strb  = is_apb(dec.tgt) ? 4'hf :
                                lane_strb(bb.addr[1:0], `SIZE_BYTE);
                  s_nxt.wdata = 32'h0000_0000;
               end else begin
                  // Bridges share this clock, so the request passes straight on.
                  s_nxt.state = addr_decode_pkg::ST_ACCESS;
                  s_nxt.tv    = 5'h01 << dec.tgt;
                  s_nxt.wr    = i_req.write;
                  if (is_apb(dec.tgt)) begin
                     s_nxt.strb  = 4'hf;
                     s_nxt.wdata = replicate(i_req.wdata, bb.addr[1:0], i_req.size);
                  end else begin
                     s_nxt.strb  = lane_strb(bb.addr[1:0], i_req.size);
                     s_nxt.wdata = i_req.wdata;
                  end
               end
            end
         end
         addr_decode_pkg::ST_ACCESS: begin
            if (sel_rsp.ready) begin
               s_nxt.state     = addr_decode_pkg::ST_RESP;
               s_nxt.tv        = 5'h00;
               s_nxt.rsp.done  = 1'b1;
               s_nxt.rsp.err   = sel_rsp.err;
               s_nxt.rsp.rdata = sel_rsp.rdata;
            end
         end
         addr_decode_pkg::ST_RMW_RD: begin
            if (sel_rsp.ready) begin
               if (sel_rsp.err || !s_r.bb_wr) begin
                  s_nxt.state     = addr_decode_pkg::ST_RESP;
                  s_nxt.tv        = 5'h00;
                  s_nxt.rsp.done  = 1'b1;
                  s_nxt.rsp.err   = sel_rsp.err;
                  s_nxt.rsp.rdata = {31'h0000_0000, cur_bit};
               end else begin
                  // The bus stays held between read and write for atomicity.
                  s_nxt.state = addr_decode_pkg::ST_RMW_WR;
                  s_nxt.wr    = 1'b1;
                  s_nxt.wdata = {4{new_byte}};
               end
            end
         end
         addr_decode_pkg::ST_RMW_WR: begin
            if (sel_rsp.ready) begin
               s_nxt.state     = addr_decode_pkg::ST_RESP;
               s_nxt.tv        = 5'h00;
               s_nxt.rsp.done  = 1'b1;
               s_nxt.rsp.err   = sel_rsp.err;
               s_nxt.rsp.rdata = 32'h0000_0000;
            end
         end
         addr_decode_pkg::ST_RESP: begin
            s_nxt.state    = addr_decode_pkg::ST_IDLE;
            s_nxt.rsp.done = 1'b0;
            s_nxt.rdy      = 1'b1;
         end
         default: begin
            s_nxt       = '0;
            s_nxt.state = addr_decode_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_r       <= '0;
         s_r.state <= addr_decode_pkg::ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------------

   assign o_req_ready = s_r.rdy;
   assign o_rsp       = s_r.rsp;
   assign o_clk_en    = clk_en;

   always_comb begin
      for (int i = 0; i < `TGT_NUM; i++) begin
         o_tgt[i].valid = s_r.tv[i];
         o_tgt[i].write = s_r.wr;
         o_tgt[i].win   = s_r.win;
         o_tgt[i].strb  = s_r.strb;
         o_tgt[i].addr  = s_r.addr;
         o_tgt[i].wdata = s_r.wdata;
      end
   end

endmodule

// ==== inc/addr_decode_pkg.sv ====
package addr_decode_pkg;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,
      ST_ACCESS = 5'h02,
      ST_RMW_RD = 5'h04,
      ST_RMW_WR = 5'h08,
      ST_RESP   = 5'h10
   } state_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        is_core;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } up_req_t;

   typedef struct packed {
      logic        done;
      logic        err;
      logic [31:0] rdata;
   } up_rsp_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [4:0]  win;
      logic [3:0]  strb;
      logic [31:0] addr;
      logic [31:0] wdata;
   } tgt_req_t;

   typedef struct packed {
      logic        ready;
      logic        err;
      logic [31:0] rdata;
   } tgt_rsp_t;

   typedef struct packed {
      logic [2:0]  wr;
      logic [31:0] val;
   } clken_upd_t;

   typedef struct packed {
      logic [31:0] highspeed_bus_clock_enable;
      logic [31:0] periph_bus1_clock_enable;
      logic [31:0] periph_bus2_clock_enable;
   } clken_t;

   typedef struct packed {
      logic        ok;
      logic [2:0]  tgt;
      logic [4:0]  win;
   } dec_t;

   typedef struct packed {
      logic        alias_hit;
      logic [31:0] addr;
      logic [2:0]  bitpos;
   } bb_t;

   typedef struct packed {
      state_t      state;
      logic        rdy;
      logic [2:0]  tgt;
      logic [4:0]  tv;
      logic        wr;
      logic [4:0]  win;
      logic [3:0]  strb;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        bb_wr;
      logic        bb_val;
      logic [2:0]  bitpos;
      up_rsp_t     rsp;
   } core_st_t;

endpackage

// ==== inc/addr_decode_regs.svh ====
`ifndef ADDR_DECODE_REGS_SVH
`define ADDR_DECODE_REGS_SVH

// ----------------------------------------------------------------------------
// Region and window layout
// ----------------------------------------------------------------------------
`define RGN_MSB            31
`define RGN_LSB            29
`define RGN_CODE           3'h0
`define RGN_SRAM           3'h1
`define RGN_PERIPH         3'h2
`define WIN_MSB            14
`define WIN_LSB            10

`define FLASH_BASE         32'h0800_0000
`define FLASH_SIZE         32'h0008_0000
`define SRAM_BASE          32'h2000_0000
`define SRAM_SIZE          32'h0001_8000
`define PERIPH_BASE        32'h4000_0000
`define SRAM_ALIAS_BASE    32'h2200_0000
`define PERIPH_ALIAS_BASE  32'h4200_0000
`define ALIAS_SIZE         32'h0200_0000

`define BUS1_BASE          32'h4000_0000
`define BUS1_SIZE          32'h0000_8000
`define BUS2_BASE          32'h4001_0000
`define BUS2_SIZE          32'h0000_8000
`define SDIO_BASE          32'h4001_8000
`define SDIO_SIZE          32'h0000_0400
`define HS_BASE            32'h4002_0000
`define HS_SIZE            32'h0000_8000

// One bit per 1 KB window index; a clear bit is reserved space.
`define BUS1_WIN_MASK      32'h3bfe_dc3f
`define BUS2_WIN_MASK      32'hffff_ffff
`define HS_WIN_MASK        32'h0110_1113
`define QSPI_WIN           5'h10
`define SDIO_WIN           5'h1f
`define HS_WIN_SRAM        5'h02
`define HS_WIN_FLASH       5'h08

// ----------------------------------------------------------------------------
// Targets, sizes and reset values
// ----------------------------------------------------------------------------
`define TGT_FLASH          3'h0
`define TGT_SRAM           3'h1
`define TGT_HS             3'h2
`define TGT_BUS2           3'h3
`define TGT_BUS1           3'h4
`define TGT_NUM            5

`define SIZE_BYTE          2'h0
`define SIZE_HALF          2'h1
`define SIZE_WORD          2'h2

`define HS_CLKEN_RST       32'h0000_0104
`define BUS_CLKEN_RST      32'h0000_0000

`endif

// ==== tb/addr_decode_sva.sv ====
`timescale 1ns/100ps
`include "addr_decode_regs.svh"

// ----------------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------------
module addr_decode_sva (
   input wire logic                                     i_clk,
   input wire logic                                     i_rst_b,
   input wire addr_decode_pkg::up_req_t                 i_req,
   input wire logic                                     o_req_ready,
   input wire addr_decode_pkg::up_rsp_t                 o_rsp,
   input wire addr_decode_pkg::tgt_req_t [`TGT_NUM-1:0] o_tgt,
   input wire addr_decode_pkg::tgt_rsp_t [`TGT_NUM-1:0] i_tgt,
   input wire addr_decode_pkg::clken_upd_t              i_clken_upd,
   input wire addr_decode_pkg::clken_t                  o_clk_en
);
   logic                take;
   logic                al_hit;
   logic                al_rd_r;
   logic                sram_al_r;
   logic [31:0]         bb_addr_r;
   logic [`TGT_NUM-1:0] vld;

   assign take   = i_req.valid && o_req_ready;
   assign al_hit = i_req.addr[31:25] == 7'h11 || i_req.addr[31:25] == 7'h21;

   always_comb for (int i = 0; i < `TGT_NUM; i++) vld[i] = o_tgt[i].valid;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         al_rd_r   <= 1'b0;
         sram_al_r <= 1'b0;
         bb_addr_r <= 32'h0;
      end else if (take) begin
         al_rd_r   <= al_hit && i_req.is_core && !i_req.write;
         sram_al_r <= al_hit && i_req.is_core && i_req.addr[29];
         bb_addr_r <= {12'h200, i_req.addr[24:5]};
      end else if (o_rsp.done) begin
         al_rd_r   <= 1'b0;
         sram_al_r <= 1'b0;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   chk_take_busy: assert property (take |=> !o_req_ready)
      else $error("ready stayed high after a take");
   chk_ready_back: assert property (o_rsp.done |=> o_req_ready && !o_rsp.done)
      else $error("ready not back one cycle after done");
   chk_reserved_err: assert property (take && i_req.addr[31:29] == 3'h5
      |-> ##[1:2] o_rsp.done && o_rsp.err) else $error("reserved region not refused");
   chk_dma_alias: assert property (take && !i_req.is_core && al_hit
      |-> ##[1:2] o_rsp.done && o_rsp.err && o_rsp.rdata == 32'h0)
      else $error("alias access by dma not refused");
   chk_alias_bit: assert property (o_rsp.done && al_rd_r |-> o_rsp.rdata[31:1] == 31'h0)
      else $error("alias read wider than one bit");
   chk_one_target: assert property ($onehot0(vld))
      else $error("more than one target selected");
   chk_bus1_win: assert property (o_tgt[4].valid |-> o_tgt[4].strb == 4'hf &&
      o_tgt[4].addr[31:15] == 17'h08000 && o_tgt[4].win == o_tgt[4].addr[14:10] &&
      o_tgt[4].win < 5'h1e) else $error("bad first peripheral bus transfer");
   chk_bus2_range: assert property (o_tgt[3].valid |-> o_tgt[3].strb == 4'hf &&
      o_tgt[3].addr[31:15] == 17'h08002) else $error("bad second peripheral bus transfer");
   chk_bb_addr: assert property (o_tgt[1].valid && sram_al_r |->
      o_tgt[1].addr == bb_addr_r) else $error("alias translated to wrong address");
   chk_rmw_lane: assert property (o_tgt[1].valid && o_tgt[1].write && sram_al_r
      |-> $onehot(o_tgt[1].strb) && $past(o_tgt[1].valid))
      else $error("alias write is not a single byte modify");
   chk_clken_load: assert property (i_clken_upd.wr[1] |=>
      o_clk_en.periph_bus1_clock_enable == $past(i_clken_upd.val))
      else $error("clock enable not loaded");
endmodule

bind system_address_decode_bitband addr_decode_sva i_addr_decode_sva (
   .i_clk      (i_clk),
   .i_rst_b    (i_rst_b),
   .i_req      (i_req),
   .o_req_ready(o_req_ready),
   .o_rsp      (o_rsp),
   .o_tgt      (o_tgt),
   .i_tgt      (i_tgt),
   .i_clken_upd(i_clken_upd),
   .o_clk_en   (o_clk_en)
);

// ==== tb/tb_system_address_decode_bitband.sv ====
`timescale 1ns/100ps
`include "addr_decode_regs.svh"

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: %h vs %h", $time, g, e); end end

module tb_system_address_decode_bitband;
   typedef struct packed {logic err; logic rd; logic [31:0] v;} exp_t;

   logic                                     i_clk;
   logic                                     i_rst_b;
   logic                                     slow;
   addr_decode_pkg::up_req_t                 req;
   addr_decode_pkg::clken_upd_t              cu;
   logic                                     rdy;
   addr_decode_pkg::up_rsp_t                 rsp;
   addr_decode_pkg::tgt_req_t [`TGT_NUM-1:0] tq;
   addr_decode_pkg::tgt_rsp_t [`TGT_NUM-1:0] tr;
   addr_decode_pkg::clken_t                  en;
   exp_t                                     exp_q[$];
   exp_t                                     ex;
   int                                       n_fail;
   int                                       n_tests;
   logic [31:0]                              w0;
   logic [31:0]                              ba;
   logic                                     v;
   logic [31:0]                              map_a [10] = '{32'h4000_7800, 32'h4000_77fc,
      32'h4001_7ffc, 32'h4002_6000, 32'h4002_4000, 32'ha000_0000, 32'h0800_0000,
      32'h2001_8000, 32'h4000_1800, 32'h4002_6400};
   logic [9:0]                               map_e = 10'h3b1;

   system_address_decode_bitband i_system_address_decode_bitband (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(req), .o_req_ready(rdy), .o_rsp(rsp),
      .o_tgt(tq), .i_tgt(tr), .i_clken_upd(cu), .o_clk_en(en));
   tgt_model i_tgt_model (.i_clk(i_clk), .i_slow(slow), .i_req(tq), .o_rsp(tr));

   always #2 i_clk = ~i_clk;

   // ----------------------------------------------------------------------------
   // Response monitor
   // ----------------------------------------------------------------------------
   always @(posedge i_clk) begin
      if (rsp.done === 1'b1) begin
         `CHK(exp_q.size() != 0, 1'b1)
         ex = exp_q.size() != 0 ? exp_q.pop_front() : '1;
         `CHK(rsp.err, ex.err)
         if (ex.rd) `CHK(rsp.rdata, ex.v)
      end
   end

   // ----------------------------------------------------------------------------
   // Drivers
   // ----------------------------------------------------------------------------
   // Flags f: write, core, error expected, read data checked.
   task automatic acc(input logic [3:0] f, input logic [1:0] sz, input logic [31:0] a, d, ev);
      exp_q.push_back({f[1], f[0], ev});
      @(posedge i_clk);
      req  <= {1'b1, f[3], f[2], sz, a, d};
      slow <= 1'($urandom_range(0, 1));
      @(posedge i_clk);
      for (int k = 0; k < 50 && rdy !== 1'b1; k++) @(posedge i_clk);
      req.valid <= 1'b0;
   endtask

   task automatic upd(input logic [2:0] wr, input logic [31:0] val);
      @(posedge i_clk);
      cu <= {wr, val};
      @(posedge i_clk);
      cu.wr <= 3'h0;
   endtask

   task automatic do_reset();
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      repeat (12) @(posedge i_clk);
      `CHK(en, {32'h0000_0104, 64'h0})
      i_rst_b <= 1'b1;
      $display("test reset done");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #(20000 * 4);
      n_fail++;
      end_of_test();
   end

   // ----------------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------------
   initial begin
      i_clk   = 1'b0;
      i_rst_b = 1'b0;
      slow    = 1'b0;
      req     = '0;
      cu      = '0;
      n_fail  = 0;
      n_tests = 0;
      void'($urandom(32'h7b389377));
      do_reset();
      acc(4'hc, `SIZE_WORD, 32'h2000_0000, 32'h1, 32'h0);
      acc(4'h6, `SIZE_WORD, 32'h4000_0000, 32'h0, 32'h0);
      upd(3'h7, 32'hffff_ffff);
      $display("test clock gating done");
      w0 = $urandom;
      acc(4'hc, `SIZE_WORD, 32'h2000_0100, w0, 32'h0);
      acc(4'hc, `SIZE_BYTE, 32'h2000_0101, 32'h0000_c300, 32'h0);
      acc(4'hc, `SIZE_HALF, 32'h2000_0102, 32'h5e7a_0000, 32'h0);
      acc(4'h5, `SIZE_WORD, 32'h2000_0100, 32'h0, {24'h5e7ac3, w0[7:0]});
      $display("test byte order done");
      for (int i = 0; i < 10; i++) begin
         acc({2'h1, map_e[i], 1'b1}, `SIZE_WORD, map_a[i], 32'h0, 32'h0);
      end
      $display("test address map done");
      acc(4'hc, `SIZE_BYTE, 32'h4001_0c01, 32'h0000_5a00, 32'h0);
      acc(4'h5, `SIZE_WORD, 32'h4001_0c00, 32'h0, 32'h5a5a_5a5a);
      acc(4'hc, `SIZE_HALF, 32'h4000_0002, 32'h1234_0000, 32'h0);
      acc(4'h5, `SIZE_WORD, 32'h4000_0000, 32'h0, 32'h1234_1234);
      $display("test narrow writes done");
      w0 = $urandom;
      acc(4'hc, `SIZE_WORD, 32'h2000_0300, w0, 32'h0);
      for (int i = 0; i < 32; i++) begin
         v     = 1'($urandom_range(0, 1));
         w0[i] = v;
         ba    = 32'h2200_6000 + 32'(i / 8 * 32 + i % 8 * 4);
         acc(4'hc, `SIZE_WORD, ba, {31'h0, v}, 32'h0);
         acc(4'h5, `SIZE_WORD, ba, 32'h0, {31'h0, v});
      end
      acc(4'h5, `SIZE_WORD, 32'h2000_0300, 32'h0, w0);
      acc(4'h2, `SIZE_WORD, 32'h2200_6008, 32'h0, 32'h0);
      acc(4'h1, `SIZE_WORD, 32'h2000_0300, 32'h0, w0);
      $display("test sram bit band done");
      acc(4'hc, `SIZE_WORD, 32'h4001_0800, 32'h0, 32'h0);
      acc(4'hc, `SIZE_WORD, 32'h4221_000c, 32'h1, 32'h0);
      acc(4'h5, `SIZE_WORD, 32'h4221_000c, 32'h0, 32'h1);
      acc(4'h5, `SIZE_WORD, 32'h4001_0800, 32'h0, 32'h0808_0808);
      acc(4'h2, `SIZE_WORD, 32'h4221_000c, 32'h0, 32'h0);
      $display("test peripheral bit band done");
      upd(3'h2, 32'h0);
      acc(4'h6, `SIZE_WORD, 32'h4000_0000, 32'h0, 32'h0);
      for (int k = 0; k < 100 && exp_q.size() != 0; k++) @(posedge i_clk);
      do_reset();
      acc(4'h6, `SIZE_WORD, 32'h4001_0800, 32'h0, 32'h0);
      acc(4'h4, `SIZE_WORD, 32'h2000_0300, 32'h0, 32'h0);
      for (int k = 0; k < 100 && exp_q.size() != 0; k++) @(posedge i_clk);
      `CHK(exp_q.size(), 0)
      end_of_test();
   end
endmodule

// ==== tb/tgt_model.sv ====
`timescale 1ns/100ps
`include "addr_decode_regs.svh"

// ----------------------------------------------------------------------------
// Memory-like model of all downstream targets
// ----------------------------------------------------------------------------
module tgt_model (
   input  wire logic                                     i_clk,
   input  wire logic                                     i_slow,
   input  wire addr_decode_pkg::tgt_req_t [`TGT_NUM-1:0] i_req,
   output      addr_decode_pkg::tgt_rsp_t [`TGT_NUM-1:0] o_rsp
);
   logic [31:0] mem [logic [32:0]];
   logic [1:0]  cnt [`TGT_NUM];
   logic [32:0] k;

   initial begin
      o_rsp = '0;
      foreach (cnt[i]) cnt[i] = 2'h0;
   end

   // Targets answer on the system clock; a slow target waits three cycles.
   always @(posedge i_clk) begin
      for (int i = 0; i < `TGT_NUM; i++) begin
         k = {i[2:0], i_req[i].addr[31:2]};
         if (i_req[i].valid && !o_rsp[i].ready) begin
            if (cnt[i] >= (i_slow ? 2'h3 : 2'h0)) begin
               o_rsp[i].ready <= 1'b1;
               o_rsp[i].rdata <= mem.exists(k) ? mem[k] : 32'h0;
            end else begin
               cnt[i] <= cnt[i] + 2'h1;
            end
         end else begin
            o_rsp[i].ready <= 1'b0;
            cnt[i]         <= 2'h0;
            // Read data is not held after the answer.
            o_rsp[i].rdata <= ~o_rsp[i].rdata;
            if (o_rsp[i].ready && i_req[i].write) begin
               if (!mem.exists(k)) mem[k] = 32'h0;
               for (int j = 0; j < 4; j++) begin
                  if (i_req[i].strb[j]) mem[k][8*j+:8] = i_req[i].wdata[8*j+:8];
               end
            end
         end
      end
   end
endmodule
